// *** pkg/psm_pkg.sv ***
// Package for the pin state and port multiplexer block
package psm_pkg;

   localparam int ADDR_W = 16;
   localparam int NGRP   = 5;
   // Register indices, byte address is four times the index
   localparam logic [15:0] IDX_MODE [NGRP] =
      '{16'h1FD0, 16'h1FD1, 16'h1FD8, 16'h1FD9, 16'h1FE1};
   localparam logic [15:0] IDX_DIR  [NGRP] =
      '{16'h1FD2, 16'h1FD3, 16'h1FDA, 16'h1FDB, 16'h1FE3};
   localparam logic [15:0] IDX_VAL  [NGRP] =
      '{16'h1FD4, 16'h1FD5, 16'h1FDC, 16'h1FDD, 16'h1FE5};
   localparam logic [15:0] IDX_PIN  [NGRP] =
      '{16'h1FD6, 16'h1FD7, 16'h1FDE, 16'h1FDF, 16'h1FE7};
   // Reset values per group: port1..port4, upper port
   localparam logic [7:0] RST_MODE [NGRP] =
      '{8'h00, 8'h80, 8'h01, 8'h00, 8'hFF};
   localparam logic [7:0] RST_DIR  [NGRP] =
      '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [7:0] RST_VAL  [NGRP] =
      '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   // Group numbers and special pins
   localparam int G_P2 = 1;
   localparam int G_P3 = 2;
   localparam int G_EP = 4;
   localparam int NUM_CS = 6;
   localparam int CLKOUT_BIT = 7;
   localparam int UPPER_LSB = 16;
   // Register kinds
   localparam logic [1:0] K_MODE = 2'h0;
   localparam logic [1:0] K_DIR  = 2'h1;
   localparam logic [1:0] K_VAL  = 2'h2;
   localparam logic [1:0] K_PIN  = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PM_RUN, PM_BUS_IDLE, PM_LOW_PWR, PM_HOLD
   } psm_pwr_e;

   typedef struct packed {
      logic       hit;
      logic [1:0] kind;
      logic [2:0] grp;
   } psm_dec_s;

endpackage

// *** hw/psm_pin_mux.sv ***
// Pin state control and port/peripheral multiplexer with AXI4-Lite regs
// Contract
// - Port pins follow mode: port regs or peripheral
// - Low power chip select high, floats on ack
// - Hold: chip selects float on pull-up
// - Low power address low, floats on ack/hold
// - Low power upper address low, floats on ack
// - Hold: upper address floats, port keeps value
// - Bus idle: upper address keeps previous address
// - Low power strobes high, pull-up on ack
// - Low power latch/fetch low, pull-down on ack
// - Post-reset pin state until mode written
// - First chip select boot level by variant
`timescale 1ns/1ns
module psm_pin_mux #(
   parameter bit BOOT_CS_LOW = 1'b0
) (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite slave
   input  wire logic [psm_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [psm_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   // Operating state from the core
   input  wire logic                       core_idle,
   input  wire logic                       core_powerdown,
   input  wire logic                       core_hold,
   input  wire logic                       ext_bus_idle,
   input  wire logic                       bus_grant_ack_n,
   // Core bus request
   input  wire logic [19:0]                core_addr,
   input  wire logic [15:0]                core_ad_o,
   input  wire logic                       core_ad_oe,
   input  wire logic                       core_rd_n,
   input  wire logic                       core_wr_n,
   input  wire logic                       core_bhe_n,
   input  wire logic                       core_ale,
   input  wire logic                       core_fetch,
   input  wire logic [5:0]                 core_cs_n,
   // Peripheral side of the multiplexed pins
   input  wire logic [4:0][7:0]            per_o,
   input  wire logic [4:0][7:0]            per_oe,
   // Port pins
   input  wire logic [7:0]                 p1_i,
   output logic [7:0]                      p1_o,
   output logic [7:0]                      p1_oe,
   input  wire logic [7:0]                 p2_i,
   output logic [7:0]                      p2_o,
   output logic [7:0]                      p2_oe,
   input  wire logic [7:0]                 p3_i,
   output logic [7:0]                      p3_o,
   output logic [7:0]                      p3_oe,
   input  wire logic [3:0]                 p4_i,
   output logic [3:0]                      p4_o,
   output logic [3:0]                      p4_oe,
   input  wire logic [3:0]                 upper_port_i,
   output logic [3:0]                      upper_port_o,
   output logic [3:0]                      upper_port_oe,
   output logic [4:0][7:0]                 pin_q,
   output logic [5:0]                      cs_pull_up,
   // Bus pins
   output logic [15:0]                     lower_address_bits_o,
   output logic [15:0]                     lower_address_bits_oe,
   input  wire logic [15:0]                muxed_addr_data_i,
   output logic [15:0]                     muxed_addr_data_o,
   output logic [15:0]                     muxed_addr_data_oe,
   output logic [15:0]                     bus_data_q,
   output logic                            read_strobe_n_o,
   output logic                            write_strobe_n_o,
   output logic                            high_byte_enable_n_o,
   output logic                            strobe_oe,
   output logic                            strobe_pull_up,
   output logic                            addr_latch_en_o,
   output logic                            fetch_indicator_o,
   output logic                            status_oe,
   output logic                            status_pull_dn
);
   import psm_pkg::*;

   typedef struct packed {
      logic [4:0][7:0] mode;
      logic [4:0][7:0] dir;
      logic [4:0][7:0] val;
      logic [4:0]      cfg;
      logic [4:0][7:0] pin;
      logic [4:0][7:0] po;
      logic [4:0][7:0] poe;
      logic [5:0]      cs_pu;
      logic [3:0]      last_up;
      logic [15:0]     la_o;
      logic [15:0]     la_oe;
      logic [15:0]     ad_o;
      logic [15:0]     ad_oe;
      logic [15:0]     ad_q;
      logic [2:0]      strb;
      logic            strb_oe;
      logic            strb_pu;
      logic [1:0]      stat;
      logic            stat_oe;
      logic            stat_pd;
      logic            aw_held;
      logic [15:0]     aw_addr;
      logic            w_held;
      logic [7:0]      w_byte;
      logic            w_en;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [1:0]      rresp;
      logic [7:0]      rbyte;
   } psm_st_s;

   psm_st_s  s_r;
   psm_st_s  s_nxt;
   psm_pwr_e pwr;
   psm_dec_s wd;
   psm_dec_s rd;
   logic     ack;

   // Register decode, shared by the write and read paths
   function automatic psm_dec_s decode(input logic [15:0] a);
      psm_dec_s d;
      d = '0;
      for (int g = 0; g < NGRP; g++) begin
         if (a == {IDX_MODE[g][13:0], 2'b00}) begin
            d = '{1'b1, K_MODE, 3'(g)};
         end else if (a == {IDX_DIR[g][13:0], 2'b00}) begin
            d = '{1'b1, K_DIR, 3'(g)};
         end else if (a == {IDX_VAL[g][13:0], 2'b00}) begin
            d = '{1'b1, K_VAL, 3'(g)};
         end else if (a == {IDX_PIN[g][13:0], 2'b00}) begin
            d = '{1'b1, K_PIN, 3'(g)};
         end
      end
      return d;
   endfunction

   // Port as programmed: direction 1 is open drain, so a 1 floats
   function automatic logic [1:0] port_drv(input logic d, input logic v);
      return {~d | ~v, v};
   endfunction

   assign ack = ~bus_grant_ack_n;

   always_comb begin
      logic [1:0] pd;
      pd  = '0;
      s_nxt = s_r;
      wd  = decode(s_r.aw_addr);
      rd  = decode(araddr);
      // Hold wins over low power, which wins over an idle bus
      if (core_hold) begin
         pwr = PM_HOLD;
      end else if (core_idle || core_powerdown) begin
         pwr = PM_LOW_PWR;
      end else if (ext_bus_idle) begin
         pwr = PM_BUS_IDLE;
      end else begin
         pwr = PM_RUN;
      end

      // AXI write path: address and data taken in either order
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (awvalid && s_r.awready) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.aw_addr = awaddr;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.w_held = 1'b1;
         s_nxt.w_byte = wdata[7:0];
         s_nxt.w_en   = wstrb[0];
      end
      if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = wd.hit ? RESP_OKAY : RESP_SLVERR;
         if (wd.hit && s_r.w_en) begin
            case (wd.kind)
               K_MODE: begin
                  s_nxt.mode[wd.grp] = s_r.w_byte;
                  s_nxt.cfg[wd.grp]  = 1'b1;
               end
               K_DIR: s_nxt.dir[wd.grp] = s_r.w_byte;
               K_VAL: s_nxt.val[wd.grp] = s_r.w_byte;
               default: ;
            endcase
         end
      end
      s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

      // AXI read path: one cycle from address to data
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = rd.hit ? RESP_OKAY : RESP_SLVERR;
         case (rd.kind)
            K_MODE: s_nxt.rbyte = s_r.mode[rd.grp];
            K_DIR:  s_nxt.rbyte = s_r.dir[rd.grp];
            K_VAL:  s_nxt.rbyte = s_r.val[rd.grp];
            default: s_nxt.rbyte = s_r.pin[rd.grp];
         endcase
         if (!rd.hit) begin
            s_nxt.rbyte = '0;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Pin sampling
      s_nxt.pin = {{4'h0, upper_port_i}, {4'h0, p4_i}, p3_i, p2_i, p1_i};
      s_nxt.ad_q = muxed_addr_data_i;
      // Upper address remembered only while a bus cycle runs
      if (pwr == PM_RUN) begin
         s_nxt.last_up = core_addr[19:16];
      end

      // Multiplexed pins
      s_nxt.cs_pu = '0;
      for (int g = 0; g < NGRP; g++) begin
         for (int b = 0; b < 8; b++) begin
            pd = port_drv(s_r.dir[g][b], s_r.val[g][b]);
            if (s_r.mode[g][b]) begin
               pd = {per_oe[g][b], per_o[g][b]};
            end
            if (!s_r.cfg[g]) begin
               // Weak pull-up until configured; clock out stays live, first chip select at boot level, upper port driven high
               pd = 2'b00;
               if (g == G_P2 && b == CLKOUT_BIT) begin
                  pd = {per_oe[g][b], per_o[g][b]};
               end else if (g == G_P3 && b == 0) begin
                  pd = {1'b1, ~BOOT_CS_LOW};
               end else if (g == G_EP) begin
                  pd = 2'b11;
               end
            end else if (g == G_P3 && b < NUM_CS && s_r.mode[g][b]) begin
               case (pwr)
                  PM_HOLD: pd = 2'b00;
                  PM_LOW_PWR: pd = ack ? 2'b00 : 2'b11;
                  default: pd = {1'b1, core_cs_n[b]};
               endcase
               s_nxt.cs_pu[b] = ~pd[1];
            end else if (g == G_EP && b < 4 && s_r.mode[g][b]) begin
               // Only four upper address pins exist
               case (pwr)
                  PM_HOLD: pd = 2'b00;
                  PM_LOW_PWR: pd = ack ? 2'b00 : 2'b10;
                  PM_BUS_IDLE: pd = {1'b1, s_r.last_up[b[1:0]]};
                  default: pd = {1'b1, core_addr[UPPER_LSB + b]};
               endcase
            end else if (g == G_P2 && b == CLKOUT_BIT &&
                         s_r.mode[g][b] && core_powerdown &&
                         !core_hold) begin
               pd = 2'b11;
            end
            s_nxt.poe[g][b] = pd[1];
            s_nxt.po[g][b]  = pd[0];
         end
      end

      // Dedicated bus pins
      case (pwr)
         PM_HOLD: begin
            s_nxt.la_oe   = '0;
            s_nxt.ad_oe   = '0;
            s_nxt.la_o    = '0;
            s_nxt.ad_o    = '0;
            s_nxt.strb    = 3'b111;
            s_nxt.strb_oe = 1'b0;
            s_nxt.stat    = 2'b00;
            s_nxt.stat_oe = 1'b0;
         end
         PM_LOW_PWR: begin
            s_nxt.la_oe   = {16{~ack}};
            s_nxt.ad_oe   = {16{~ack}};
            s_nxt.la_o    = '0;
            s_nxt.ad_o    = '0;
            s_nxt.strb    = 3'b111;
            s_nxt.strb_oe = ~ack;
            s_nxt.stat    = 2'b00;
            s_nxt.stat_oe = ~ack;
         end
         PM_BUS_IDLE: begin
            s_nxt.la_oe   = '1;
            s_nxt.ad_oe   = '1;
            s_nxt.la_o    = '0;
            s_nxt.ad_o    = '0;
            s_nxt.strb    = 3'b111;
            s_nxt.strb_oe = 1'b1;
            s_nxt.stat    = 2'b00;
            s_nxt.stat_oe = 1'b1;
         end
         default: begin
            s_nxt.la_oe   = '1;
            s_nxt.ad_oe   = {16{core_ad_oe}};
            s_nxt.la_o    = core_addr[15:0];
            s_nxt.ad_o    = core_ad_o;
            s_nxt.strb    = {core_rd_n, core_wr_n, core_bhe_n};
            s_nxt.strb_oe = 1'b1;
            s_nxt.stat    = {core_ale, core_fetch};
            s_nxt.stat_oe = 1'b1;
         end
      endcase
      s_nxt.strb_pu = ~s_nxt.strb_oe;
      s_nxt.stat_pd = ~s_nxt.stat_oe;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r          <= '0;
         s_r.strb     <= 3'b111;
         s_r.strb_oe  <= 1'b1;
         s_r.stat_oe  <= 1'b1;
         s_r.la_oe    <= '1;
         s_r.ad_oe    <= '1;
         s_r.poe[G_P3][0] <= 1'b1;
         s_r.po[G_P3][0]  <= ~BOOT_CS_LOW;
         for (int g = 0; g < NGRP; g++) begin
            s_r.mode[g] <= RST_MODE[g];
            s_r.dir[g]  <= RST_DIR[g];
            s_r.val[g]  <= RST_VAL[g];
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   assign awready = s_r.awready;
   assign wready  = s_r.wready;
   assign bvalid  = s_r.bvalid;
   assign bresp   = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid  = s_r.rvalid;
   assign rresp   = s_r.rresp;
   assign rdata   = {24'h0, s_r.rbyte};
   assign p1_o = s_r.po[0];
   assign p1_oe = s_r.poe[0];
   assign p2_o = s_r.po[1];
   assign p2_oe = s_r.poe[1];
   assign p3_o = s_r.po[2];
   assign p3_oe = s_r.poe[2];
   assign p4_o = s_r.po[3][3:0];
   assign p4_oe = s_r.poe[3][3:0];
   assign upper_port_o = s_r.po[G_EP][3:0];
   assign upper_port_oe = s_r.poe[G_EP][3:0];
   assign pin_q = s_r.pin;
   assign cs_pull_up = s_r.cs_pu;
   assign lower_address_bits_o = s_r.la_o;
   assign lower_address_bits_oe = s_r.la_oe;
   assign muxed_addr_data_o = s_r.ad_o;
   assign muxed_addr_data_oe = s_r.ad_oe;
   assign bus_data_q = s_r.ad_q;
   assign read_strobe_n_o = s_r.strb[2];
   assign write_strobe_n_o = s_r.strb[1];
   assign high_byte_enable_n_o = s_r.strb[0];
   assign strobe_oe = s_r.strb_oe;
   assign strobe_pull_up = s_r.strb_pu;
   assign addr_latch_en_o = s_r.stat[1];
   assign fetch_indicator_o = s_r.stat[0];
   assign status_oe = s_r.stat_oe;
   assign status_pull_dn = s_r.stat_pd;

   // Checks
   logic lp_now;
   assign lp_now = (core_idle || core_powerdown) && !core_hold;

   sequence bus_busy;
      !core_hold && !core_idle && !core_powerdown && !ext_bus_idle;
   endsequence
   sequence bus_goes_idle;
      bus_busy ##1 (!core_hold && !core_idle && !core_powerdown &&
                    ext_bus_idle && s_r.cfg[G_EP] && s_r.mode[G_EP][0]);
   endsequence

   a_port_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.cfg[0] && s_r.mode[0][0] |=> p1_o[0] == $past(per_o[0][0]))
      else $error("port pin does not follow peripheral");
   a_cs_drive_hi: assert property (@(posedge aclk) disable iff (!aresetn)
      lp_now && !ack && s_r.cfg[G_P3] && s_r.mode[G_P3][1]
      |=> p3_oe[1] && p3_o[1] && !cs_pull_up[1])
      else $error("chip select not driven high in low power");
   a_cs_hold_flt: assert property (@(posedge aclk) disable iff (!aresetn)
      core_hold && s_r.cfg[G_P3] && s_r.mode[G_P3][1]
      |=> !p3_oe[1] && cs_pull_up[1])
      else $error("chip select driven during hold");
   a_addr_lowpwr: assert property (@(posedge aclk) disable iff (!aresetn)
      lp_now |=> (lower_address_bits_oe == {16{$past(!ack)}}) &&
      (lower_address_bits_o == 16'h0000) && (muxed_addr_data_o == 16'h0000))
      else $error("address pins wrong in low power");
   a_upper_lowpwr: assert property (@(posedge aclk) disable iff (!aresetn)
      lp_now && s_r.cfg[G_EP] && s_r.mode[G_EP][0]
      |=> upper_port_oe[0] == $past(!ack) && !upper_port_o[0])
      else $error("upper address wrong in low power");
   a_upper_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      core_hold && s_r.cfg[G_EP] && !s_r.mode[G_EP][0]
      |=> upper_port_o[0] == $past(s_r.val[G_EP][0]))
      else $error("upper port value lost in hold");
   a_upper_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_goes_idle |=> upper_port_oe[0] &&
      upper_port_o[0] == $past(core_addr[UPPER_LSB], 2))
      else $error("upper address not kept on idle bus");
   a_strobe_lowpwr: assert property (@(posedge aclk) disable iff (!aresetn)
      lp_now |=> read_strobe_n_o && write_strobe_n_o && high_byte_enable_n_o &&
      strobe_oe != strobe_pull_up && strobe_pull_up == $past(ack))
      else $error("strobes wrong in low power");
   a_status_lowpwr: assert property (@(posedge aclk) disable iff (!aresetn)
      lp_now |=> !addr_latch_en_o && !fetch_indicator_o &&
      status_pull_dn == $past(ack) && status_oe == $past(!ack))
      else $error("latch enable wrong in low power");
   a_post_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_r.cfg[0] |=> p1_oe == 8'h00)
      else $error("unconfigured port driven");
   a_boot_cs: assert property (@(posedge aclk)
      $rose(aresetn) |-> p3_oe[0] && p3_o[0] == !BOOT_CS_LOW)
      else $error("boot chip select level wrong");

endmodule // psm_pin_mux

// *** test/psm_ext_master.sv ***
// External master model sharing the address/data lines
`timescale 1ns/1ns
module psm_ext_master (
   // Clock
   input  wire logic        aclk,
   // Grant and the device drive
   input  wire logic        bus_grant_ack_n,
   input  wire logic [15:0] dev_o,
   input  wire logic [15:0] dev_oe,
   input  wire logic [15:0] drive_val,
   // Resolved lines
   output logic [15:0]      ad_level
);
   logic [15:0] last_r = 16'h0000;
   // Released lines wander, so a stale value never passes
   always_comb begin
      ad_level = (dev_o & dev_oe) | (~last_r & ~dev_oe);
      // Drive only once granted and the device has let go
      if (!bus_grant_ack_n && dev_oe == 16'h0000) begin
         ad_level = drive_val;
      end
   end
   always_ff @(posedge aclk) begin
      last_r <= ad_level;
   end
endmodule // psm_ext_master

// *** test/psm_pin_mux_tb.sv ***
// Self-checking bench for the pin state and port multiplexer
`timescale 1ns/1ns
module psm_pin_mux_tb;
   import psm_pkg::*;
   logic            aclk = 1'b0;
   logic            aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic            awready, wready, bvalid, arready, rvalid;
   logic [1:0]      bresp, rresp;
   logic [3:0]      wstrb;
   logic [15:0]     awaddr, araddr, ext_drive, bus_data_q;
   logic [31:0]     wdata, rdata;
   logic            core_idle, core_powerdown, core_hold, ext_bus_idle;
   logic            bus_grant_ack_n, core_ad_oe, core_rd_n, core_wr_n;
   logic            core_bhe_n, core_ale, core_fetch;
   logic [19:0]     core_addr;
   logic [15:0]     core_ad_o, lower_address_bits_o, lower_address_bits_oe;
   logic [15:0]     muxed_addr_data_i, muxed_addr_data_o, muxed_addr_data_oe;
   logic [5:0]      core_cs_n, cs_pull_up;
   logic [4:0][7:0] per_o, per_oe, pin_q;
   logic [7:0]      p1_i, p1_o, p1_oe, p2_i, p2_o, p2_oe, p3_i, p3_o, p3_oe;
   logic [3:0]      p4_i, p4_o, p4_oe, upper_port_i, upper_port_o;
   logic [3:0]      upper_port_oe;
   logic            read_strobe_n_o, write_strobe_n_o, high_byte_enable_n_o;
   logic            strobe_oe, strobe_pull_up, addr_latch_en_o;
   logic            fetch_indicator_o, status_oe, status_pull_dn;
   logic [46:0]     bus_lvl;
   int              errors = 0;
   int              comparisons = 0;

   psm_pin_mux #(.BOOT_CS_LOW(1'b0)) i_psm_pin_mux (.*);
   psm_ext_master i_psm_ext_master (.aclk(aclk),
      .bus_grant_ack_n(bus_grant_ack_n), .dev_o(muxed_addr_data_o),
      .dev_oe(muxed_addr_data_oe), .drive_val(ext_drive),
      .ad_level(muxed_addr_data_i));
   // Undriven port pins rest on the weak pull-up
   assign p1_i = p1_o | ~p1_oe;
   assign p2_i = p2_o | ~p2_oe;
   assign p3_i = p3_o | ~p3_oe;
   assign p4_i = p4_o | ~p4_oe;
   assign upper_port_i = upper_port_o | ~upper_port_oe;
   assign bus_lvl = {p3_o[5:0], lower_address_bits_o, muxed_addr_data_o,
      upper_port_o, read_strobe_n_o, write_strobe_n_o, high_byte_enable_n_o,
      addr_latch_en_o, fetch_indicator_o};
   always #5 aclk = ~aclk;

   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask

   task automatic hang();
      $display("unexpected response expected answer seen none");
      errors++;
      finish_test();
   endtask

   // Pins lag their cause by one register stage
   task automatic settle();
      repeat (3) @(posedge aclk);
      #1;
   endtask

   task automatic state(logic [3:0] st, logic ack_n);
      @(posedge aclk);
      {core_hold, core_powerdown, core_idle, ext_bus_idle} <= st;
      bus_grant_ack_n <= ack_n;
      settle();
   endtask

   task automatic wr(logic [15:0] idx, logic [7:0] d, logic [1:0] resp);
      @(posedge aclk);
      awaddr  <= 16'(idx << 2);
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (bvalid !== 1'b1) hang();
      chk("bresp", resp, bresp);
      bready <= 1'b0;
   endtask

   task automatic rd(logic [15:0] idx, logic [7:0] d, logic [1:0] resp);
      @(posedge aclk);
      araddr  <= 16'(idx << 2);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (rvalid !== 1'b1) hang();
      chk("read", {resp, 24'h000000, d}, {rresp, rdata});
      rready <= 1'b0;
   endtask

   task automatic bus_chk(logic g);
      logic [31:0] aoe;
      aoe = {lower_address_bits_oe, muxed_addr_data_oe};
      chk("cs oe", g ? 6'h00 : 6'h3F, p3_oe[5:0]);
      chk("cs pull", g ? 6'h3F : 6'h00, cs_pull_up);
      chk("addr oe", g ? 32'h0 : 32'hFFFFFFFF, aoe);
      chk("upper oe", g ? 4'h0 : 4'hF, upper_port_oe);
      chk("strobe", g ? 2'b01 : 2'b10, {strobe_oe, strobe_pull_up});
      chk("status", g ? 2'b01 : 2'b10, {status_oe, status_pull_dn});
      if (!g) chk("levels", {6'h3F, 36'h0, 5'b11100}, bus_lvl);
   endtask

   task automatic t_after_reset();
      settle();
      chk("port1 oe", 8'h00, p1_oe);
      chk("cs0", 2'b11, {p3_o[0], p3_oe[0]});
      chk("cs other oe", 5'h00, p3_oe[5:1]);
      chk("upper", 8'hFF, {upper_port_o, upper_port_oe});
   endtask

   task automatic t_regs();
      for (int g = 0; g < NGRP; g++) begin
         rd(IDX_MODE[g], RST_MODE[g], RESP_OKAY);
         rd(IDX_DIR[g], RST_DIR[g], RESP_OKAY);
         rd(IDX_VAL[g], RST_VAL[g], RESP_OKAY);
      end
      rd(16'h0000, 8'h00, RESP_SLVERR);
      wr(16'h0000, 8'h12, RESP_SLVERR);
      wr(IDX_PIN[0], 8'h00, RESP_OKAY);
      rd(IDX_PIN[0], 8'hFF, RESP_OKAY);
      @(posedge aclk);
      wstrb <= 4'hE;
      wr(IDX_VAL[0], 8'h00, RESP_OKAY);
      rd(IDX_VAL[0], 8'hFF, RESP_OKAY);
      wstrb <= 4'hF;
   endtask

   task automatic t_port_sel();
      @(posedge aclk);
      per_o[0]  <= 8'h3C;
      per_oe[0] <= 8'hFF;
      wr(IDX_DIR[0], 8'h00, RESP_OKAY);
      wr(IDX_VAL[0], 8'hA5, RESP_OKAY);
      wr(IDX_MODE[0], 8'h0F, RESP_OKAY);
      for (int s = 0; s < 3; s++) begin
         state(4'b0010 << s, s != 2);
         chk("port1", 16'hACFF, {p1_o, p1_oe});
      end
      chk("pin q", 8'hAC, pin_q[0]);
      rd(IDX_PIN[0], 8'hAC, RESP_OKAY);
   endtask

   task automatic t_low_power();
      wr(IDX_MODE[G_P3], 8'h3F, RESP_OKAY);
      wr(IDX_MODE[G_EP], 8'hFF, RESP_OKAY);
      wr(IDX_MODE[G_P2], 8'h80, RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
         state(k[1] ? 4'b0100 : 4'b0010, k[0]);
         bus_chk(!k[0]);
         chk("clock out", k[1] ? 2'b11 : 2'b00, {p2_o[7], p2_oe[7]});
      end
   endtask

   task automatic t_run_idle();
      @(posedge aclk);
      {core_rd_n, core_wr_n, core_bhe_n, core_ale, core_fetch} <= 5'b01011;
      core_cs_n  <= 6'h2A;
      core_ad_o  <= 16'h1234;
      core_ad_oe <= 1'b1;
      core_addr  <= 20'hA5678;
      state(4'b0000, 1'b1);
      chk("run", {6'h2A, 32'h56781234, 4'hA, 5'b01011}, bus_lvl);
      // Address must change in the same edge as the idle entry
      @(posedge aclk);
      ext_bus_idle <= 1'b1;
      core_addr    <= 20'h30000;
      settle();
      chk("idle upper", 8'hAF, {upper_port_o, upper_port_oe});
      chk("idle bus", {6'h2A, 32'h0, 4'hA, 5'b11100}, bus_lvl);
   endtask

   task automatic t_hold();
      wr(IDX_DIR[G_P3], 8'h00, RESP_OKAY);
      wr(IDX_VAL[G_P3], 8'h40, RESP_OKAY);
      state(4'b1000, 1'b0);
      bus_chk(1'b1);
      chk("port3 top", 4'b0111, {p3_o[7:6], p3_oe[7:6]});
      chk("bus in", 16'hC35A, bus_data_q);
      wr(IDX_MODE[G_EP], 8'h00, RESP_OKAY);
      wr(IDX_DIR[G_EP], 8'h00, RESP_OKAY);
      wr(IDX_VAL[G_EP], 8'h05, RESP_OKAY);
      settle();
      chk("upper port", 8'h5F, {upper_port_o, upper_port_oe});
      state(4'b0001, 1'b1);
      chk("upper port", 8'h5F, {upper_port_o, upper_port_oe});
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {core_idle, core_powerdown, core_hold, ext_bus_idle} = 4'h0;
      {core_ad_oe, core_ale, core_fetch} = 3'h0;
      {bus_grant_ack_n, core_rd_n, core_wr_n, core_bhe_n} = 4'hF;
      {awaddr, araddr, core_ad_o} = 48'h0;
      wdata = 32'h0;
      wstrb = 4'hF;
      core_addr = 20'h00000;
      core_cs_n = 6'h3F;
      per_o = 40'h0;
      per_oe = 40'h0;
      ext_drive = 16'hC35A;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_after_reset();
      t_regs();
      t_port_sel();
      t_low_power();
      t_run_idle();
      t_hold();
      finish_test();
   end
endmodule // psm_pin_mux_tb
